// ===== pevq_counter_qual.sv
// Performance event qualification: turns event sources into a per-cycle counter increment.
// Assumes all sources are synchronous to ref_clk_in and that the counter adds inc_out each cycle.
`timescale 1ns/100ps

module pevq_counter_qual
	import pevq_pkg::*;
#(
	parameter int ISSUE_W = PEVQ_ISSUE_W
) (
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic rst_in,
	// Counter control
	input wire logic [4:0] event_sel_in,
	input wire logic negate_cond_in,
	// Event sources
	input wire pevq_src_s src_in,
	// Results
	output logic [PEVQ_INC_W-1:0] inc_out,
	output logic [1:0] line_state_out,
	output logic negate_eff_out,
	output logic [2:0] table_occupancy_out
);

	// ----------------------------------------
	// Graduation qualification
	// ----------------------------------------
	logic [ISSUE_W-1:0] grad;
	logic [PEVQ_INC_W-1:0] grad_cnt;
	logic [PEVQ_INC_W-1:0] load_cnt;
	logic [PEVQ_INC_W-1:0] fp_cnt;
	logic store_grad;
	logic sc_grad;

	// An op only graduates once done and oldest; speculative completions never count
	assign grad = src_in.done & src_in.oldest;

	// Per-slot sums of graduating instructions; a multiply/divide adds two to grad_cnt
	always_comb begin
		grad_cnt = '0;
		load_cnt = '0;
		fp_cnt = '0;
		for (int i = 0; i < ISSUE_W; i++) begin
			if (grad[i]) begin
				grad_cnt = grad_cnt + (src_in.is_muldiv[i] ? 4'h2 : 4'h1);
				load_cnt = load_cnt + {3'h0, src_in.is_load[i]};
				fp_cnt = fp_cnt + {3'h0, src_in.is_fp[i]};
			end
		end
	end

	assign store_grad = |(grad & src_in.is_store);
	assign sc_grad = |(grad & src_in.is_sc);

	// ----------------------------------------
	// Miss tracking table occupancy
	// ----------------------------------------
	logic [PEVQ_TABLE_INTERNAL-1:0] int_slot_r;
	logic ext_slot_r;
	logic ext_accept;

	// External requests only ever land in the reserved slot; a second one while full is dropped
	assign ext_accept = src_in.table_enter && src_in.table_enter_ext && !ext_slot_r;

	// Reserved external slot; the external sequencer frees it with a cycle that has table_enter_ext low
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			ext_slot_r <= 1'b0;
		end else if (ext_accept) begin
			ext_slot_r <= 1'b1;
		end else if (!src_in.table_enter_ext) begin
			ext_slot_r <= 1'b0;
		end
	end

	// Internal slots track requests entering the queue, data-cache or not, up to four; refill dispatch frees one unless an entry is taken that cycle
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			int_slot_r <= '0;
		end else if (src_in.queue_enter && !(&int_slot_r)) begin
			int_slot_r <= {int_slot_r[PEVQ_TABLE_INTERNAL-2:0], 1'b1};
		end else if (src_in.refill_sent) begin
			int_slot_r <= {1'b0, int_slot_r[PEVQ_TABLE_INTERNAL-1:1]};
		end
	end

	always_comb begin
		table_occupancy_out = {2'h0, ext_slot_r};
		for (int i = 0; i < PEVQ_TABLE_INTERNAL; i++) begin
			table_occupancy_out = table_occupancy_out + {2'h0, int_slot_r[i]};
		end
	end

	// ----------------------------------------
	// One-cycle-late event capture
	// ----------------------------------------
	logic [PEVQ_INC_W-1:0] grad_cnt_r;
	logic [PEVQ_INC_W-1:0] load_cnt_r;
	logic [PEVQ_INC_W-1:0] fp_cnt_r;
	logic store_r;
	logic sc_r;
	logic intv_r;
	logic inval_r;
	logic pref_r;
	logic pref_miss_r;
	logic xlat_r;
	logic br_r;
	logic dcq_r;
	logic refill_r;
	logic upd_clean_r;
	logic upd_shared_r;
	logic [1:0] intv_state_r;
	logic [1:0] inval_state_r;

	// Pipeline graduation counts so they are added the cycle after graduation
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			grad_cnt_r <= PEVQ_INC_RST;
			load_cnt_r <= PEVQ_INC_RST;
			fp_cnt_r <= PEVQ_INC_RST;
			store_r <= 1'b0;
			sc_r <= 1'b0;
		end else begin
			grad_cnt_r <= grad_cnt;
			load_cnt_r <= load_cnt;
			fp_cnt_r <= fp_cnt;
			store_r <= store_grad;
			sc_r <= sc_grad;
		end
	end

	// Pipeline single-shot events; registering also cuts long paths from the caches
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			intv_r <= 1'b0;
			inval_r <= 1'b0;
			pref_r <= 1'b0;
			pref_miss_r <= 1'b0;
			xlat_r <= 1'b0;
			br_r <= 1'b0;
			dcq_r <= 1'b0;
			refill_r <= 1'b0;
			upd_clean_r <= 1'b0;
			upd_shared_r <= 1'b0;
		end else begin
			intv_r <= ext_accept && !src_in.table_enter_inval;
			inval_r <= ext_accept && src_in.table_enter_inval;
			pref_r <= src_in.pref_tag_check;
			pref_miss_r <= src_in.pref_tag_check && src_in.pref_refill;
			xlat_r <= src_in.xlat_miss;
			br_r <= src_in.br_restore;
			dcq_r <= src_in.queue_enter && src_in.queue_enter_dcache;
			refill_r <= src_in.refill_sent;
			upd_clean_r <= src_in.upd_clean;
			upd_shared_r <= src_in.upd_shared;
		end
	end

	// Line state of a hit, held one cycle; a no-hit cycle shows invalid
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			intv_state_r <= PEVQ_LINE_INVALID;
			inval_state_r <= PEVQ_LINE_INVALID;
		end else begin
			intv_state_r <= src_in.intv_hit ? src_in.hit_state : PEVQ_LINE_INVALID;
			inval_state_r <= src_in.inval_hit ? src_in.hit_state : PEVQ_LINE_INVALID;
		end
	end

	// ----------------------------------------
	// Increment select
	// ----------------------------------------
	logic state_sel;

	assign state_sel = (event_sel_in == PEVQ_EV_INTV_STATE) ||
		(event_sel_in == PEVQ_EV_INVAL_STATE);
	assign negate_eff_out = negate_cond_in ^ state_sel;

	// Combinational so the counter adds the value in the cycle it is chosen
	always_comb begin
		inc_out = '0;
		line_state_out = PEVQ_LINE_INVALID;
		case (event_sel_in)
			PEVQ_EV_EXT_INTV: inc_out = {3'h0, intv_r};
			PEVQ_EV_EXT_INVAL: inc_out = {3'h0, inval_r};
			PEVQ_EV_UNUSED: inc_out = '0;
			PEVQ_EV_GRAD_INSN: inc_out = grad_cnt_r;
			PEVQ_EV_PREF_EXEC: inc_out = {3'h0, pref_r};
			PEVQ_EV_PREF_MISS: inc_out = {3'h0, pref_miss_r};
			PEVQ_EV_GRAD_LOAD: inc_out = load_cnt_r;
			PEVQ_EV_GRAD_STORE: inc_out = {3'h0, store_r};
			PEVQ_EV_GRAD_SC: inc_out = {3'h0, sc_r};
			PEVQ_EV_GRAD_FP: inc_out = fp_cnt_r;
			PEVQ_EV_QW_WB: inc_out = {3'h0, src_in.qw_wb_valid};
			PEVQ_EV_XLAT_MISS: inc_out = {3'h0, xlat_r};
			PEVQ_EV_BR_MISP: inc_out = {3'h0, br_r};
			PEVQ_EV_DC_MISS: inc_out = {3'h0, dcq_r};
			PEVQ_EV_SC_MISS: inc_out = {3'h0, refill_r};
			PEVQ_EV_WAY_MISP: inc_out = {3'h0, src_in.way_retry && !src_in.way_retry_ifetch};
			PEVQ_EV_INTV_STATE: line_state_out = intv_state_r;
			PEVQ_EV_INVAL_STATE: line_state_out = inval_state_r;
			PEVQ_EV_UPD_CLEAN: inc_out = {3'h0, upd_clean_r};
			PEVQ_EV_UPD_SHARED: inc_out = {3'h0, upd_shared_r};
			default: inc_out = '0;
		endcase
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	property p_intv;
		@(posedge ref_clk_in) disable iff (rst_in)
		(ext_accept && !src_in.table_enter_inval && event_sel_in == PEVQ_EV_EXT_INTV)
		|=> (inc_out == 4'h1 || event_sel_in != PEVQ_EV_EXT_INTV);
	endproperty
	a_intv: assert property (p_intv) else $error("intervention not counted");

	property p_inval;
		@(posedge ref_clk_in) disable iff (rst_in)
		(ext_accept && src_in.table_enter_inval) ##1 (event_sel_in == PEVQ_EV_EXT_INVAL)
		|-> inc_out == 4'h1;
	endproperty
	a_inval: assert property (p_inval) else $error("invalidate not counted");

	property p_unused;
		@(posedge ref_clk_in) disable iff (rst_in)
		(event_sel_in == PEVQ_EV_UNUSED) |-> inc_out == 4'h0;
	endproperty
	a_unused: assert property (p_unused) else $error("unused event counted");

	property p_grad;
		@(posedge ref_clk_in) disable iff (rst_in)
		##1 (event_sel_in == PEVQ_EV_GRAD_INSN) |-> inc_out == $past(grad_cnt);
	endproperty
	a_grad: assert property (p_grad) else $error("graduation count wrong");

	property p_load_max;
		@(posedge ref_clk_in) disable iff (rst_in)
		(event_sel_in == PEVQ_EV_GRAD_LOAD) |-> inc_out <= 4'h4;
	endproperty
	a_load_max: assert property (p_load_max) else $error("load increment above four");

	property p_pref_miss;
		@(posedge ref_clk_in) disable iff (rst_in)
		(event_sel_in == PEVQ_EV_PREF_MISS && inc_out != 4'h0) |->
		$past(src_in.pref_tag_check) && $past(src_in.pref_refill);
	endproperty
	a_pref_miss: assert property (p_pref_miss) else $error("prefetch miss without cause");

	property p_state;
		@(posedge ref_clk_in) disable iff (rst_in)
		src_in.intv_hit ##1 (event_sel_in == PEVQ_EV_INTV_STATE) |->
		line_state_out == $past(src_in.hit_state);
	endproperty
	a_state: assert property (p_state) else $error("intervention state wrong");

	property p_negate;
		@(posedge ref_clk_in) disable iff (rst_in)
		(event_sel_in == PEVQ_EV_INVAL_STATE) |-> negate_eff_out != negate_cond_in;
	endproperty
	a_negate: assert property (p_negate) else $error("negation not inverted");

	property p_occ;
		@(posedge ref_clk_in) disable iff (rst_in)
		table_occupancy_out <= 3'h5;
	endproperty
	a_occ: assert property (p_occ) else $error("table over five entries");

	property p_pref_exec;
		@(posedge ref_clk_in) disable iff (rst_in)
		src_in.pref_tag_check ##1 (event_sel_in == PEVQ_EV_PREF_EXEC) |-> inc_out == 4'h1;
	endproperty
	a_pref_exec: assert property (p_pref_exec) else $error("prefetch check not counted");

	// Judged from the raw slot bits so a broken capture path cannot hide behind itself
	property p_store;
		@(posedge ref_clk_in) disable iff (rst_in)
		(|(src_in.done & src_in.oldest & src_in.is_store)) ##1
		(event_sel_in == PEVQ_EV_GRAD_STORE) |-> inc_out == 4'h1;
	endproperty
	a_store: assert property (p_store) else $error("graduated store not counted");

	property p_sc;
		@(posedge ref_clk_in) disable iff (rst_in)
		(|(src_in.done & src_in.oldest & src_in.is_sc)) ##1
		(event_sel_in == PEVQ_EV_GRAD_SC) |-> inc_out == 4'h1;
	endproperty
	a_sc: assert property (p_sc) else $error("store-conditional not counted");

	property p_fp_max;
		@(posedge ref_clk_in) disable iff (rst_in)
		(event_sel_in == PEVQ_EV_GRAD_FP) |-> inc_out <= 4'h4;
	endproperty
	a_fp_max: assert property (p_fp_max) else $error("fp increment above four");

	property p_qw;
		@(posedge ref_clk_in) disable iff (rst_in)
		(event_sel_in == PEVQ_EV_QW_WB && src_in.qw_wb_valid) |-> inc_out == 4'h1;
	endproperty
	a_qw: assert property (p_qw) else $error("quadword writeback not counted");

	property p_xlat;
		@(posedge ref_clk_in) disable iff (rst_in)
		src_in.xlat_miss ##1 (event_sel_in == PEVQ_EV_XLAT_MISS) |-> inc_out == 4'h1;
	endproperty
	a_xlat: assert property (p_xlat) else $error("translation miss not counted");

	property p_br;
		@(posedge ref_clk_in) disable iff (rst_in)
		src_in.br_restore ##1 (event_sel_in == PEVQ_EV_BR_MISP) |-> inc_out == 4'h1;
	endproperty
	a_br: assert property (p_br) else $error("branch restore not counted");

	property p_way;
		@(posedge ref_clk_in) disable iff (rst_in)
		(event_sel_in == PEVQ_EV_WAY_MISP && src_in.way_retry &&
		!src_in.way_retry_ifetch) |-> inc_out == 4'h1;
	endproperty
	a_way: assert property (p_way) else $error("way retry not counted");

	property p_inval_state;
		@(posedge ref_clk_in) disable iff (rst_in)
		src_in.inval_hit ##1 (event_sel_in == PEVQ_EV_INVAL_STATE) |->
		line_state_out == $past(src_in.hit_state);
	endproperty
	a_inval_state: assert property (p_inval_state) else $error("invalidate state wrong");

	c_grad4: cover property (@(posedge ref_clk_in) disable iff (rst_in) grad_cnt_r == 4'h8);
	c_dirty: cover property (@(posedge ref_clk_in) disable iff (rst_in)
		intv_state_r == PEVQ_LINE_DIRTY_EXCL);
	c_full: cover property (@(posedge ref_clk_in) disable iff (rst_in)
		table_occupancy_out == 3'h5);

endmodule // pevq_counter_qual

// ===== pevq_pkg.sv
// Package for the performance event qualification block.
// Assumes one processor clock; event sources are synchronous to it.
package pevq_pkg;

	// ----------------------------------------
	// Event selection codes
	// ----------------------------------------
	localparam logic [4:0] PEVQ_EV_EXT_INTV = 5'h0c;
	localparam logic [4:0] PEVQ_EV_EXT_INVAL = 5'h0d;
	localparam logic [4:0] PEVQ_EV_UNUSED = 5'h0e;
	localparam logic [4:0] PEVQ_EV_GRAD_INSN = 5'h0f;
	localparam logic [4:0] PEVQ_EV_PREF_EXEC = 5'h10;
	localparam logic [4:0] PEVQ_EV_PREF_MISS = 5'h11;
	localparam logic [4:0] PEVQ_EV_GRAD_LOAD = 5'h12;
	localparam logic [4:0] PEVQ_EV_GRAD_STORE = 5'h13;
	localparam logic [4:0] PEVQ_EV_GRAD_SC = 5'h14;
	localparam logic [4:0] PEVQ_EV_GRAD_FP = 5'h15;
	localparam logic [4:0] PEVQ_EV_QW_WB = 5'h16;
	localparam logic [4:0] PEVQ_EV_XLAT_MISS = 5'h17;
	localparam logic [4:0] PEVQ_EV_BR_MISP = 5'h18;
	localparam logic [4:0] PEVQ_EV_DC_MISS = 5'h19;
	localparam logic [4:0] PEVQ_EV_SC_MISS = 5'h1a;
	localparam logic [4:0] PEVQ_EV_WAY_MISP = 5'h1b;
	localparam logic [4:0] PEVQ_EV_INTV_STATE = 5'h1c;
	localparam logic [4:0] PEVQ_EV_INVAL_STATE = 5'h1d;
	localparam logic [4:0] PEVQ_EV_UPD_CLEAN = 5'h1e;
	localparam logic [4:0] PEVQ_EV_UPD_SHARED = 5'h1f;

	// ----------------------------------------
	// Sizes and encodings
	// ----------------------------------------
	localparam int PEVQ_ISSUE_W = 4;
	localparam int PEVQ_INC_W = 4;
	localparam int PEVQ_TABLE_ENTRIES = 5;
	localparam int PEVQ_TABLE_INTERNAL = 4;
	localparam logic [1:0] PEVQ_LINE_INVALID = 2'h0;
	localparam logic [1:0] PEVQ_LINE_SHARED = 2'h1;
	localparam logic [1:0] PEVQ_LINE_CLEAN_EXCL = 2'h2;
	localparam logic [1:0] PEVQ_LINE_DIRTY_EXCL = 2'h3;
	localparam logic [4:0] PEVQ_SEL_RST = 5'h00;
	localparam logic [3:0] PEVQ_INC_RST = 4'h0;

	// ----------------------------------------
	// Event source bundle
	// ----------------------------------------
	typedef struct packed {
		logic [PEVQ_ISSUE_W-1:0] done;
		logic [PEVQ_ISSUE_W-1:0] oldest;
		logic [PEVQ_ISSUE_W-1:0] is_muldiv;
		logic [PEVQ_ISSUE_W-1:0] is_load;
		logic [PEVQ_ISSUE_W-1:0] is_fp;
		logic [PEVQ_ISSUE_W-1:0] is_store;
		logic [PEVQ_ISSUE_W-1:0] is_sc;
		logic table_enter;
		logic table_enter_ext;
		logic table_enter_inval;
		logic pref_tag_check;
		logic pref_refill;
		logic qw_wb_valid;
		logic xlat_miss;
		logic br_restore;
		logic queue_enter;
		logic queue_enter_dcache;
		logic refill_sent;
		logic way_retry;
		logic way_retry_ifetch;
		logic intv_hit;
		logic inval_hit;
		logic [1:0] hit_state;
		logic upd_clean;
		logic upd_shared;
	} pevq_src_s;

endpackage

// ===== pevq_src_model.sv
// Behavioural model of the pipeline and cache event sources.
// Assumes the bench calls its tasks; source lines change only at falling edges.
`timescale 1ns/100ps

module pevq_src_model
	import pevq_pkg::*;
(
	// Clock
	input wire logic ref_clk_in,
	// Event sources
	output pevq_src_s src_out
);
	// ----------------------------------------
	// Source drivers
	// ----------------------------------------
	// Idle level is all low
	initial begin
		src_out = '0;
	end

	// One-cycle event; dropped so a stale pulse never counts twice
	task automatic pulse(input pevq_src_s s);
		@(negedge ref_clk_in);
		src_out = s;
		@(negedge ref_clk_in);
		src_out = '0;
	endtask

	// Raise and keep up until drop is called
	task automatic hold(input pevq_src_s s);
		@(negedge ref_clk_in);
		src_out = s;
	endtask

	// Release at the falling edge the caller is already at
	task automatic drop();
		src_out = '0;
	endtask
endmodule // pevq_src_model

// ===== pevq_counter_qual_tb_top.sv
// Self-checking bench for the performance event qualification block.
// Assumes pevq_src_model drives the sources; bench drives at falling edges.
`timescale 1ns/100ps

module pevq_counter_qual_tb_top import pevq_pkg::*;;
	logic ref_clk_in, rst_in, negate_cond_in;
	logic [4:0] event_sel_in;
	pevq_src_s src;
	pevq_src_s v;
	logic [PEVQ_INC_W-1:0] inc_out;
	logic [1:0] line_state_out;
	logic negate_eff_out;
	logic [2:0] table_occupancy_out;
	int n_fail = 0;
	int checks = 0;
	int cycles = 0;

	pevq_counter_qual dut (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
		.event_sel_in(event_sel_in), .negate_cond_in(negate_cond_in), .src_in(src),
		.inc_out(inc_out), .line_state_out(line_state_out),
		.negate_eff_out(negate_eff_out), .table_occupancy_out(table_occupancy_out));
	pevq_src_model srcm (.ref_clk_in(ref_clk_in), .src_out(src));

	// ----------------------------------------
	// Clock, watchdog, helpers
	// ----------------------------------------
	// 250 MHz clock
	initial begin
		ref_clk_in = 1'b0;
		forever #2 ref_clk_in = ~ref_clk_in;
	end

	// Run needs under two hundred cycles; a hang is cut off well beyond that
	always @(posedge ref_clk_in) begin
		cycles++;
		if (cycles == 3000) begin
			n_fail++;
			print_verdict();
		end
	end

	task automatic chk(input string name, input logic [3:0] exp, input logic [3:0] got);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic print_verdict();
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// Pulse once; increment shows for one cycle after the sampling edge
	task automatic later(input logic [4:0] sel, input pevq_src_s s, input logic [3:0] e);
		@(negedge ref_clk_in);
		event_sel_in = sel;
		srcm.pulse(s);
		#1 chk($sformatf("inc ev%0d", sel), e, inc_out);
		@(negedge ref_clk_in);
		#1 chk("inc idle", 4'h0, inc_out);
	endtask

	// Combinational events: increment shows while the source is up
	task automatic same(input logic [4:0] sel, input pevq_src_s s, input logic [3:0] e);
		@(negedge ref_clk_in);
		event_sel_in = sel;
		srcm.hold(s);
		#1 chk($sformatf("inc ev%0d", sel), e, inc_out);
		@(negedge ref_clk_in);
		srcm.drop();
		#1 chk("inc idle", 4'h0, inc_out);
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	// External entries, refusal of a second one, occupancy limits
	task automatic t_table();
		v = '0;
		v.table_enter = 1'b1;
		v.table_enter_ext = 1'b1;
		later(PEVQ_EV_EXT_INTV, v, 4'h1);
		v.table_enter_inval = 1'b1;
		later(PEVQ_EV_EXT_INTV, v, 4'h0);
		later(PEVQ_EV_EXT_INVAL, v, 4'h1);
		srcm.hold(v);
		srcm.hold(v);
		#1 chk("occupancy ext", 4'h1, {1'b0, table_occupancy_out});
		@(negedge ref_clk_in);
		srcm.drop();
		#1 chk("inc refused", 4'h0, inc_out);
		v = '0;
		v.queue_enter = 1'b1;
		repeat (6) srcm.pulse(v);
		#1 chk("occupancy int", 4'h4, {1'b0, table_occupancy_out});
		v = '0;
		v.table_enter = 1'b1;
		v.table_enter_ext = 1'b1;
		srcm.pulse(v);
		#1 chk("occupancy full", 4'h5, {1'b0, table_occupancy_out});
		v = '0;
		v.refill_sent = 1'b1;
		repeat (4) srcm.pulse(v);
		#1 chk("occupancy drained", 4'h0, {1'b0, table_occupancy_out});
	endtask

	// Graduation counts; slot 3 is done but not oldest and must not count
	task automatic t_grad();
		v = '0;
		v.done = 4'hf;
		v.oldest = 4'h7;
		v.is_muldiv = 4'h1;
		v.is_load = 4'hf;
		v.is_fp = 4'h6;
		v.is_store = 4'h1;
		v.is_sc = 4'h1;
		later(PEVQ_EV_GRAD_INSN, v, 4'h4);
		later(PEVQ_EV_GRAD_LOAD, v, 4'h3);
		later(PEVQ_EV_GRAD_FP, v, 4'h2);
		later(PEVQ_EV_GRAD_STORE, v, 4'h1);
		later(PEVQ_EV_GRAD_SC, v, 4'h1);
		v.oldest = 4'hf;
		v.is_muldiv = 4'h3;
		v.is_sc = 4'h0;
		later(PEVQ_EV_GRAD_INSN, v, 4'h6);
		later(PEVQ_EV_GRAD_LOAD, v, 4'h4);
		later(PEVQ_EV_GRAD_SC, v, 4'h0);
		later(PEVQ_EV_GRAD_STORE, v, 4'h1);
		v.is_muldiv = 4'hf;
		later(PEVQ_EV_GRAD_INSN, v, 4'h8);
		v.done = 4'h0;
		later(PEVQ_EV_GRAD_STORE, v, 4'h0);
	endtask

	// Single-source events, the unused code, and same-cycle events
	task automatic t_misc();
		v = '0;
		v.pref_tag_check = 1'b1;
		later(PEVQ_EV_PREF_EXEC, v, 4'h1);
		later(PEVQ_EV_PREF_MISS, v, 4'h0);
		v.pref_refill = 1'b1;
		later(PEVQ_EV_PREF_MISS, v, 4'h1);
		v = '0;
		v.xlat_miss = 1'b1;
		later(PEVQ_EV_XLAT_MISS, v, 4'h1);
		v = '0;
		v.br_restore = 1'b1;
		later(PEVQ_EV_BR_MISP, v, 4'h1);
		v = '0;
		v.queue_enter = 1'b1;
		later(PEVQ_EV_DC_MISS, v, 4'h0);
		v.queue_enter_dcache = 1'b1;
		later(PEVQ_EV_DC_MISS, v, 4'h1);
		v = '0;
		v.refill_sent = 1'b1;
		later(PEVQ_EV_SC_MISS, v, 4'h1);
		v = '0;
		v.upd_clean = 1'b1;
		later(PEVQ_EV_UPD_CLEAN, v, 4'h1);
		later(PEVQ_EV_UPD_SHARED, v, 4'h0);
		v.upd_shared = 1'b1;
		later(PEVQ_EV_UPD_SHARED, v, 4'h1);
		later(PEVQ_EV_UNUSED, '1, 4'h0);
		v = '0;
		v.way_retry = 1'b1;
		same(PEVQ_EV_WAY_MISP, v, 4'h1);
		v.way_retry_ifetch = 1'b1;
		same(PEVQ_EV_WAY_MISP, v, 4'h0);
		v = '0;
		v.qw_wb_valid = 1'b1;
		same(PEVQ_EV_QW_WB, v, 4'h1);
	endtask

	// Line state of hits and the inverted negate setting
	task automatic t_state();
		v = '0;
		v.intv_hit = 1'b1;
		v.hit_state = PEVQ_LINE_DIRTY_EXCL;
		negate_cond_in = 1'b0;
		later(PEVQ_EV_INTV_STATE, v, 4'h0);
		chk("negate ev28", 4'h1, {3'b000, negate_eff_out});
		@(negedge ref_clk_in);
		srcm.pulse(v);
		#1 chk("state ev28", 4'h3, {2'b00, line_state_out});
		@(negedge ref_clk_in);
		#1 chk("state idle", 4'h0, {2'b00, line_state_out});
		v = '0;
		v.inval_hit = 1'b1;
		v.hit_state = PEVQ_LINE_SHARED;
		@(negedge ref_clk_in);
		negate_cond_in = 1'b1;
		event_sel_in = PEVQ_EV_INVAL_STATE;
		srcm.pulse(v);
		#1 chk("state ev29", 4'h1, {2'b00, line_state_out});
		chk("negate ev29", 4'h0, {3'b000, negate_eff_out});
		@(negedge ref_clk_in);
		event_sel_in = PEVQ_EV_GRAD_INSN;
		#1 chk("negate ev15", 4'h1, {3'b000, negate_eff_out});
	endtask

	// Mid-run reset empties the table; the first entry after release still counts
	task automatic t_reset();
		v = '0;
		v.queue_enter = 1'b1;
		v.intv_hit = 1'b1;
		v.hit_state = PEVQ_LINE_CLEAN_EXCL;
		@(negedge ref_clk_in);
		event_sel_in = PEVQ_EV_INTV_STATE;
		srcm.pulse(v);
		#1 chk("state ev28 clean", 4'h2, {2'b00, line_state_out});
		@(negedge ref_clk_in);
		rst_in = 1'b1;
		#1 chk("occupancy reset", 4'h0, {1'b0, table_occupancy_out});
		@(negedge ref_clk_in);
		rst_in = 1'b0;
		v = '0;
		v.table_enter = 1'b1;
		v.table_enter_ext = 1'b1;
		later(PEVQ_EV_EXT_INTV, v, 4'h1);
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		rst_in = 1'b1;
		negate_cond_in = 1'b0;
		event_sel_in = PEVQ_SEL_RST;
		repeat (5) @(posedge ref_clk_in);
		@(negedge ref_clk_in);
		rst_in = 1'b0;
		#1 chk("inc reset", 4'h0, inc_out);
		t_table();
		t_grad();
		t_misc();
		t_state();
		t_reset();
		print_verdict();
	end
endmodule // pevq_counter_qual_tb_top
